/* File: hdl/bias_dac_channel_control.sv */
// control of eight bias dac channels in two groups behind a wishbone slave
//
// Contract
// RULE1 - eight channels form two groups of four, each with own rails and range
// RULE2 - any reset zeroes codes, powers amplifiers down, clamps all outputs
// RULE3 - writing one to a channel's power enable bit powers its amplifier
// RULE4 - codes are 13-bit straight binary, same meaning in both ranges
// RULE5 - output equals code over 8192 times 10V plus range minimum
// RULE6 - broadcast write copies value into buffer and active of member channels
// RULE7 - per-channel limit of 64 settings caps upper six code bits
// RULE8 - limit acts on active register and only on later writes
// RULE9 - non-deferred channel copies buffer write to active at once
// RULE10 - deferred channel moves buffer to active only on a trigger
// RULE11 - load pin triggers only group A channels 0 and 2; soft bit all
// RULE12 - current mode selects 30mA, 90mA or 120mA short-circuit limit
// RULE13 - output stays clamped until its amplifier is powered up
// RULE14 - autorange result per group kept in status; negative is default
// RULE15 - core or interface supply low causes full reset and clamps outputs
// RULE16 - rail or reference alarm sets status, may power down chosen channels
// RULE17 - soft load bit self-clears after one clock, all deferred update together
`timescale 1ns/1ps
`default_nettype none
`include "bias_dac_params.svh"
module bias_dac_channel_control
  import bias_dac_pkg::*;
#(
  parameter int CHANS   = `CHAN_COUNT,
  parameter int CODE_W  = `CODE_WIDTH,
  parameter int LIMIT_W = `LIMIT_WIDTH,
  parameter int ALARMS  = `ALARM_COUNT
)(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`REG_ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     supplyLow,
  input  wire logic [ALARMS-1:0]        alarmIn,
  input  wire logic                     loadPin,
  input  wire logic [1:0]               rangeDetect,
  output logic      [CHANS*CODE_W-1:0]  chanCode,
  output logic      [CHANS-1:0]         ampOn,
  output logic      [CHANS-1:0]         clampOn,
  output logic      [1:0]               currentMode,
  output logic      [1:0]               rangePositive,
  output logic                          irq
);
  ctrl_state_t q;
  ctrl_state_t next_q;

  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic [2:0]                    region;
  logic [2:0]                    idx;
  logic [31:0]                   rdv;
  logic [31:0]                   wmask;
  logic [31:0]                   wd;
  logic [CHANS-1:0]              codeWe;
  logic                          bcastWe;
  logic [CHANS-1:0]              chanTrig;
  logic [CHANS-1:0]              pdnHit;
  logic [CHANS-1:0][CODE_W-1:0]  bufCodes;
  logic [CHANS-1:0][CODE_W-1:0]  actCodes;
  localparam logic [CHANS-1:0]   LOAD_SET = `LOAD_CHANS;

  function automatic ctrl_state_t reset_state();
    ctrl_state_t s;
    s           = '0;
    s.clamp     = `CLAMP_ALL;
    s.curMode   = CUR_NORMAL;
    for (int i = 0; i < CHANS; i++)
      s.limit[i] = `LIMIT_FULL;
    reset_state = s;
  endfunction

  // classic wishbone: one access per ack, ack dropped the cycle after
  assign acc    = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr     = acc && wb_we_i;
  assign rd     = acc && !wb_we_i;
  assign region = wb_adr_i[7:5];
  assign idx    = wb_adr_i[4:2];
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // unselected lanes keep the value the register reads back
  assign wd     = (rdv & ~wmask) | (wb_dat_i & wmask);

  always_comb
  begin
    rdv = `DATA_ZERO;
    case (region)
      `REG_CODE:   rdv = {{(32-CODE_W){1'b0}}, bufCodes[idx]};
      `REG_LIMIT:  rdv = {{(32-LIMIT_W){1'b0}}, q.limit[idx]};
      `REG_ACTIVE: rdv = {{(32-CODE_W){1'b0}}, actCodes[idx]};
      default:
      begin
        case (wb_adr_i)
          `ADR_PWR:   rdv = {{(32-CHANS){1'b0}}, q.pwrEn};
          `ADR_SYNC:  rdv = {{(32-2*CHANS){1'b0}}, q.member, q.defer};
          `ADR_CURR:  rdv = {30'h0, q.curMode};
          `ADR_RANGE: rdv = {30'h0, q.rangePos};
          `ADR_ALARM: rdv = {{(32-ALARMS){1'b0}}, q.alarm};
          `ADR_MASK:  rdv = {{(32-ALARMS){1'b0}}, q.mask};
          `ADR_PDN:   rdv = {{(32-CHANS){1'b0}}, q.pdnSel};
          `ADR_FLEX:  rdv = {31'h0, q.loadSel};
          default:    rdv = `DATA_ZERO;
        endcase
      end
    endcase
  end

  assign bcastWe = wr && (wb_adr_i == `ADR_BCAST);

  // the soft bit reaches every deferred channel, the pin only two of group A
  always_comb
  begin
    for (int i = 0; i < CHANS; i++)
    begin
      codeWe[i]   = wr && (region == `REG_CODE) && (idx == 3'(i));
      chanTrig[i] = q.softTrig || (q.loadEdge && LOAD_SET[i]); // RULE11 RULE17
    end
  end

  // alarms of a group hit that group only; the shared reference alarm hits both groups
  assign pdnHit = q.pdnSel & ({{4{|(q.almS2 & `ALM_GROUP_B)}}, {4{|(q.almS2 & `ALM_GROUP_A)}}}
                  & (`GROUP_A_CHANS | `GROUP_B_CHANS)); // RULE1 RULE16

  always_comb
  begin
    next_q = q;
    next_q.ack = acc;
    next_q.rdat = rd ? rdv : `DATA_ZERO;

    next_q.porS1  = supplyLow;
    next_q.porS2  = q.porS1;
    next_q.almS1  = alarmIn;
    next_q.almS2  = q.almS1;
    next_q.ldS1   = loadPin;
    next_q.ldS2   = q.ldS1;
    next_q.ldPrev = q.ldS2;
    next_q.rngS1  = rangeDetect;
    next_q.rngS2  = q.rngS1;
    next_q.loadEdge = q.loadSel && q.ldS2 && !q.ldPrev; // RULE11

    next_q.softTrig = 1'b0; // RULE17

    if (wr)
    begin
      case (wb_adr_i)
        `ADR_PWR:  next_q.pwrEn = wd[CHANS-1:0]; // RULE3
        `ADR_SYNC:
        begin
          next_q.defer  = wd[CHANS-1:0]; // RULE9 RULE10
          next_q.member = wd[`SYNC_MEMBER_LSB +: CHANS]; // RULE6
        end
        `ADR_TRIG: next_q.softTrig = wd[`TRIG_SOFT_BIT]; // RULE17
        `ADR_CURR:
        begin
          // the unused code is ignored so the limit is always one of three
          if (wd[1:0] != `CURR_INVALID)
            next_q.curMode = cur_mode_t'(wd[1:0]); // RULE12
        end
        `ADR_MASK: next_q.mask   = wd[ALARMS-1:0];
        `ADR_PDN:  next_q.pdnSel = wd[CHANS-1:0]; // RULE16
        `ADR_FLEX: next_q.loadSel = wd[`FLEX_LOAD_BIT]; // RULE11
        default:
        begin
          if (region == `REG_LIMIT)
            next_q.limit[idx] = wd[LIMIT_W-1:0]; // RULE7
        end
      endcase
    end

    // a live alarm wins over the read that clears it
    next_q.alarm = ((rd && wb_adr_i == `ADR_ALARM) ? '0 : q.alarm) | q.almS2; // RULE16
    // automatic power down overrides a simultaneous enable write
    next_q.pwrEn = next_q.pwrEn & ~pdnHit; // RULE16
    next_q.clamp = ~next_q.pwrEn; // RULE13
    next_q.irq   = |(next_q.alarm & next_q.mask);

    // range straps settle through the synchroniser before capture
    if (!q.rangeDone)
    begin
      if (q.rangeWait == `RANGE_SETTLE)
      begin
        next_q.rangePos  = q.rngS2; // RULE14
        next_q.rangeDone = 1'b1;
      end
      else
        next_q.rangeWait = q.rangeWait + 2'h1;
    end

    // supply loss: everything but the bus handshake and synchronisers
    if (q.porS2)
    begin
      next_q        = reset_state(); // RULE15 RULE2
      next_q.ack    = acc;
      next_q.rdat   = rd ? rdv : `DATA_ZERO;
      next_q.porS1  = supplyLow;
      next_q.porS2  = q.porS1;
      next_q.almS1  = alarmIn;
      next_q.almS2  = q.almS1;
      next_q.ldS1   = loadPin;
      next_q.ldS2   = q.ldS1;
      next_q.ldPrev = q.ldS2;
      next_q.rngS1  = rangeDetect;
      next_q.rngS2  = q.rngS1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      q <= reset_state(); // RULE2
    else
      q <= next_q;
  end

  // codes are stored raw; the analog string maps code/8192 of 10V onto the range
  genvar g;
  generate
    for (g = 0; g < CHANS; g++)
    begin : g_chan
      bias_dac_chan #(
        .CODE_W  (CODE_W),
        .LIMIT_W (LIMIT_W)
      ) u_chan (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .clr       (q.porS2),
        .codeWe    (codeWe[g]),
        .bcastWe   (bcastWe),
        .trig      (chanTrig[g]),
        .deferred  (q.defer[g]),
        .member    (q.member[g]),
        .limit     (q.limit[g]),
        .wrCode    (wd[CODE_W-1:0]), // RULE4
        .bcastCode (wd[CODE_W-1:0]), // RULE6
        .bufCode   (bufCodes[g]),
        .actCode   (actCodes[g])
      );
    end
  endgenerate

  assign chanCode      = actCodes;
  assign ampOn         = q.pwrEn;
  assign clampOn       = q.clamp;
  assign currentMode   = q.curMode;
  assign rangePositive = q.rangePos;
  assign irq           = q.irq;
  assign wb_dat_o      = q.rdat;
  assign wb_ack_o      = q.ack;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_pwr_write;
    wr && wb_adr_i == `ADR_PWR && !q.porS2;
  endsequence

  sequence s_pin_load;
    q.loadEdge && !q.softTrig;
  endsequence

  sequence s_trig_write;
    wr && wb_adr_i == `ADR_TRIG && wd[`TRIG_SOFT_BIT] && !q.porS2;
  endsequence

  sequence s_pin_rise;
    q.loadSel && q.ldS2 && !q.ldPrev && !q.porS2;
  endsequence

  sequence s_range_due;
    !q.rangeDone && q.rangeWait == `RANGE_SETTLE && !q.porS2;
  endsequence

  sequence s_cur_bad;
    wr && wb_adr_i == `ADR_CURR && wd[1:0] == `CURR_INVALID && !q.porS2;
  endsequence

  sequence s_alarm_a;
    (q.almS2 & `ALM_GROUP_A) != '0 && !q.porS2;
  endsequence

  a_reset_clamp: assert property ($past(rst) |-> ampOn == `PWR_OFF && clampOn == `CLAMP_ALL) // RULE2
    else $error("outputs not clamped after reset");
  a_clamp_tracks: assert property (clampOn == ~ampOn) // RULE13
    else $error("clamp does not follow amplifier power");
  a_pwr_write: assert property (s_pwr_write ##0 (pdnHit == '0) |=> ampOn == $past(wd[CHANS-1:0])) // RULE3
    else $error("power enable write not applied");
  a_soft_pulse: assert property (q.softTrig |=> !q.softTrig) // RULE17
    else $error("soft load bit did not self-clear");
  a_pin_scope: assert property (s_pin_load |-> chanTrig == `LOAD_CHANS) // RULE11
    else $error("load pin reached wrong channels");
  a_por_clamp: assert property (q.porS2 |=> ampOn == `PWR_OFF ##0 q.curMode == CUR_NORMAL) // RULE15
    else $error("supply loss did not clamp outputs");
  a_alarm_pdn: assert property ((pdnHit != '0) |=> (ampOn & $past(pdnHit)) == '0) // RULE16
    else $error("alarm did not power down selected channels");
  a_range_hold: assert property (q.rangeDone && $past(q.rangeDone) && !$past(q.porS2) |-> $stable(q.rangePos)) // RULE14
    else $error("range result changed after capture");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_ack_follows: assert property (acc |=> wb_ack_o)
    else $error("access not acknowledged");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == `DATA_ZERO)
    else $error("read data not zero outside ack");
  a_read_data: assert property (rd |=> wb_dat_o == $past(rdv))
    else $error("read data does not match register");
  a_trig_set: assert property (s_trig_write |=> q.softTrig) // RULE17
    else $error("soft load write did not raise the trigger");
  a_soft_fanout: assert property (q.softTrig |-> &chanTrig) // RULE17
    else $error("soft load did not reach every channel");
  a_pin_edge: assert property (s_pin_rise |=> q.loadEdge ##1 !q.loadEdge) // RULE11
    else $error("load pin edge not a single pulse");
  a_pin_gate: assert property (!q.loadSel |=> !q.loadEdge) // RULE11
    else $error("load pin acted while disabled");
  a_cur_ignore: assert property (s_cur_bad |=> $stable(currentMode)) // RULE12
    else $error("unused current code was accepted");
  a_cur_legal: assert property (currentMode != `CURR_INVALID) // RULE12
    else $error("current mode outside the three limits");
  a_alarm_set: assert property (q.almS2 != '0 && !q.porS2 |=> (q.alarm & $past(q.almS2)) == $past(q.almS2)) // RULE16
    else $error("live alarm not latched");
  a_alarm_keep: assert property (!rd && !q.porS2 |=> (q.alarm & $past(q.alarm)) == $past(q.alarm)) // RULE16
    else $error("alarm status lost without a read");
  a_read_clear: assert property (rd && wb_adr_i == `ADR_ALARM && !q.porS2 |=> q.alarm == $past(q.almS2)) // RULE16
    else $error("alarm read did not clear stale bits");
  a_irq_level: assert property (irq == |(q.alarm & q.mask)) // RULE16
    else $error("interrupt does not follow masked status");
  a_reset_codes: assert property ($past(rst) |-> chanCode == '0) // RULE2
    else $error("codes not zero after reset");
  a_range_take: assert property (s_range_due |=> rangePositive == $past(q.rngS2) ##0 q.rangeDone) // RULE14
    else $error("range result not captured");
  a_pdn_group: assert property (s_alarm_a |=> (ampOn & $past(q.pdnSel) & `GROUP_A_CHANS) == '0) // RULE1 RULE16
    else $error("group alarm left a selected channel on");
  a_sync_write: assert property (wr && wb_adr_i == `ADR_SYNC && !q.porS2 // RULE10
    |=> q.defer == $past(wd[CHANS-1:0]))
    else $error("deferred bits not written");
  a_flex_write: assert property (wr && wb_adr_i == `ADR_FLEX && !q.porS2 // RULE11
    |=> q.loadSel == $past(wd[`FLEX_LOAD_BIT]))
    else $error("load pin enable not written");
  a_limit_write: assert property (wr && region == `REG_LIMIT && !q.porS2 // RULE7
    |=> q.limit[$past(idx)] == $past(wd[LIMIT_W-1:0]))
    else $error("code limit not written");
endmodule // bias_dac_channel_control
`default_nettype wire

/* File: hdl/bias_dac_params.svh */
// constants for the bias dac channel control block
`ifndef BIAS_DAC_PARAMS_SVH
`define BIAS_DAC_PARAMS_SVH
`define CHAN_COUNT     8
`define CODE_WIDTH     13
`define LIMIT_WIDTH    6
`define ALARM_COUNT    5
`define CODE_ZERO      13'h0000
`define LIMIT_FULL     6'h3f
`define REG_ADR_W      8
`define REG_CODE       3'h0
`define REG_LIMIT      3'h1
`define REG_ACTIVE     3'h4
`define ADR_PWR        8'h40
`define ADR_SYNC       8'h44
`define ADR_BCAST      8'h48
`define ADR_TRIG       8'h4c
`define ADR_CURR       8'h50
`define ADR_RANGE      8'h54
`define ADR_ALARM      8'h58
`define ADR_MASK       8'h5c
`define ADR_PDN        8'h60
`define ADR_FLEX       8'h64
`define SYNC_MEMBER_LSB 8
`define TRIG_SOFT_BIT  0
`define FLEX_LOAD_BIT  0
`define CURR_INVALID   2'h3
`define GROUP_A_CHANS  8'h0f
`define GROUP_B_CHANS  8'hf0
`define LOAD_CHANS     8'h05
`define ALM_GROUP_A    5'h13
`define ALM_GROUP_B    5'h1c
`define RANGE_SETTLE   2'h2
`define PWR_OFF        8'h00
`define CLAMP_ALL      8'hff
`define DATA_ZERO      32'h0000_0000
`endif

/* File: hdl/bias_dac_pkg.sv */
// types shared by the bias dac channel control block
`include "bias_dac_params.svh"
package bias_dac_pkg;
  typedef enum logic [1:0] {
    CUR_LOW    = 2'b00,
    CUR_NORMAL = 2'b01,
    CUR_HIGH   = 2'b10
  } cur_mode_t;

  typedef struct packed {
    logic [`CODE_WIDTH-1:0] bufCode;
    logic [`CODE_WIDTH-1:0] actCode;
  } chan_state_t;

  typedef struct packed {
    logic                                      ack;
    logic [31:0]                               rdat;
    logic [`CHAN_COUNT-1:0]                    pwrEn;
    logic [`CHAN_COUNT-1:0]                    clamp;
    logic [`CHAN_COUNT-1:0]                    defer;
    logic [`CHAN_COUNT-1:0]                    member;
    logic [`CHAN_COUNT-1:0][`LIMIT_WIDTH-1:0]  limit;
    logic                                      softTrig;
    cur_mode_t                                 curMode;
    logic [1:0]                                rangePos;
    logic [1:0]                                rangeWait;
    logic                                      rangeDone;
    logic [`ALARM_COUNT-1:0]                   alarm;
    logic [`ALARM_COUNT-1:0]                   mask;
    logic [`CHAN_COUNT-1:0]                    pdnSel;
    logic                                      loadSel;
    logic                                      loadEdge;
    logic                                      irq;
    logic                                      porS1;
    logic                                      porS2;
    logic [`ALARM_COUNT-1:0]                   almS1;
    logic [`ALARM_COUNT-1:0]                   almS2;
    logic                                      ldS1;
    logic                                      ldS2;
    logic                                      ldPrev;
    logic [1:0]                                rngS1;
    logic [1:0]                                rngS2;
  } ctrl_state_t;
endpackage

/* File: hdl/bias_dac_chan.sv */
// one output channel: buffer and active code registers with code limit
`timescale 1ns/1ps
`default_nettype none
`include "bias_dac_params.svh"
module bias_dac_chan
  import bias_dac_pkg::*;
#(
  parameter int CODE_W  = `CODE_WIDTH,
  parameter int LIMIT_W = `LIMIT_WIDTH
)(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               clr,
  input  wire logic               codeWe,
  input  wire logic               bcastWe,
  input  wire logic               trig,
  input  wire logic               deferred,
  input  wire logic               member,
  input  wire logic [LIMIT_W-1:0] limit,
  input  wire logic [CODE_W-1:0]  wrCode,
  input  wire logic [CODE_W-1:0]  bcastCode,
  output logic      [CODE_W-1:0]  bufCode,
  output logic      [CODE_W-1:0]  actCode
);
  chan_state_t q;
  chan_state_t next_q;

  // ceiling on the upper bits, applied only on the way into active
  function automatic logic [CODE_W-1:0] capped(input logic [CODE_W-1:0] c);
    capped = (c[CODE_W-1 -: LIMIT_W] > limit) ? {limit, c[CODE_W-LIMIT_W-1:0]} : c; // RULE7 RULE8
  endfunction

  always_comb
  begin
    next_q = q;
    if (trig && deferred)
      next_q.actCode = capped(q.bufCode); // RULE10
    if (codeWe)
    begin
      next_q.bufCode = wrCode;
      if (!deferred)
        next_q.actCode = capped(wrCode); // RULE9
    end
    if (bcastWe && member)
    begin
      next_q.bufCode = bcastCode; // RULE6
      next_q.actCode = capped(bcastCode); // RULE6
    end
    if (clr)
      next_q = '{bufCode: `CODE_ZERO, actCode: `CODE_ZERO}; // RULE2 RULE15
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      q <= '{bufCode: `CODE_ZERO, actCode: `CODE_ZERO}; // RULE2
    else
      q <= next_q;
  end

  assign bufCode = q.bufCode;
  assign actCode = q.actCode;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_direct_update: assert property (codeWe && !deferred && !bcastWe && !clr |=> actCode == capped($past(wrCode))) // RULE9
    else $error("direct write did not reach active code");
  a_deferred_hold: assert property (codeWe && deferred && !trig && !bcastWe && !clr |=> $stable(actCode)) // RULE10
    else $error("deferred write changed active code without trigger");
  a_bcast_copy: assert property (bcastWe && member && !clr |=> bufCode == $past(bcastCode)) // RULE6
    else $error("broadcast value not stored in buffer");
  a_limit_ceiling: assert property ($changed(actCode) && !$past(clr) |-> actCode[CODE_W-1 -: LIMIT_W] <= $past(limit)) // RULE7
    else $error("active code above limit");
endmodule // bias_dac_chan
`default_nettype wire

/* File: sim/wb_host_model.sv */
// wishbone classic host model that owns the register port
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input  wire logic        sys_clk,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [7:0]  adr,
  output var  logic [3:0]  sel,
  output var  logic [31:0] dat
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    dat = 32'h0000_0000;
  end

  // entry edge leaves one idle cycle after the previous release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    // no own limit: only the bench watchdog ends a hung access
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
endmodule // wb_host_model
`default_nettype wire

/* File: sim/bias_dac_channel_control_tb.sv */
// self-checking bench for the bias dac channel control block
`timescale 1ns/1ps
`default_nettype none
module bias_dac_channel_control_tb;
  import bias_dac_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         cyc, stb, we, ack, irq;
  logic         supplyLow = 1'b0;
  logic         loadPin = 1'b0;
  logic [4:0]   alarmIn = 5'h00;
  logic [1:0]   rangeDetect = 2'h2;
  logic [1:0]   currentMode, rangePositive;
  logic [7:0]   adr, ampOn, clampOn;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat, q;
  logic [103:0] chanCode;
  int           failures = 0;
  int           samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  wb_host_model i_host (.sys_clk(sys_clk), .wb_ack_o(ack), .wb_dat_o(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(wdat));

  bias_dac_channel_control i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .supplyLow(supplyLow), .alarmIn(alarmIn), .loadPin(loadPin), .rangeDetect(rangeDetect),
    .chanCode(chanCode), .ampOn(ampOn), .clampOn(clampOn), .currentMode(currentMode),
    .rangePositive(rangePositive), .irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] code(input int i);
    return {19'h0, chanCode[13*i +: 13]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      check(code(i), 32'h0);
    check({24'h0, ampOn}, 32'h00);
    check({24'h0, clampOn}, 32'hff);
    check({30'h0, rangePositive}, 32'h2);
  endtask

  task automatic t_power();
    wr(8'h40, 32'h5a);
    check({24'h0, ampOn}, 32'h5a);
    check({24'h0, clampOn}, 32'ha5);
  endtask

  task automatic t_direct();
    wr(8'h0c, 32'h1fff);
    check(code(3), 32'h1fff);
    rd(8'h8c);
    check(q, 32'h1fff);
  endtask

  task automatic t_defer();
    wr(8'h64, 32'h1);
    wr(8'h44, 32'h15);
    wr(8'h00, 32'h0aaa);
    wr(8'h08, 32'h0555);
    wr(8'h10, 32'h1000);
    check(code(0), 32'h0);
    loadPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(code(0), 32'h0aaa);
    check(code(2), 32'h0555);
    check(code(4), 32'h0);
    loadPin <= 1'b0;
    wr(8'h4c, 32'h1);
    // active moves one edge after the trigger pulse
    @(posedge sys_clk);
    check(code(4), 32'h1000);
    wr(8'h10, 32'h0777);
    @(posedge sys_clk);
    check(code(4), 32'h1000);
    rd(8'h4c);
    check(q, 32'h0);
  endtask

  task automatic t_bcast();
    wr(8'h44, 32'h3000);
    wr(8'h48, 32'h0123);
    check(code(4), 32'h0123);
    check(code(5), 32'h0123);
    check(code(6), 32'h0);
    rd(8'h14);
    check(q, 32'h0123);
  endtask

  task automatic t_limit();
    wr(8'h04, 32'h1fff);
    wr(8'h24, 32'h10);
    check(code(1), 32'h1fff);
    wr(8'h04, 32'h1fff);
    check(code(1), 32'h087f);
    rd(8'h04);
    check(q, 32'h1fff);
  endtask

  task automatic t_current();
    for (int m = 0; m < 3; m++)
    begin
      wr(8'h50, m);
      check({30'h0, currentMode}, m);
    end
    wr(8'h50, 32'h3);
    check({30'h0, currentMode}, 32'h2);
  endtask

  task automatic t_alarm();
    wr(8'h5c, 32'h1);
    wr(8'h60, 32'h02);
    alarmIn <= 5'h01;
    repeat (6) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    check({24'h0, ampOn}, 32'h58);
    alarmIn <= 5'h04;
    repeat (6) @(posedge sys_clk);
    rd(8'h58);
    check(q, 32'h05);
    alarmIn <= 5'h00;
    repeat (4) @(posedge sys_clk);
    rd(8'h58);
    check(q, 32'h04);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic t_supply();
    supplyLow <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(code(3), 32'h0);
    check({24'h0, clampOn}, 32'hff);
    check({30'h0, currentMode}, 32'h1);
    check({30'h0, rangePositive}, 32'h0);
    supplyLow <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({30'h0, rangePositive}, 32'h2);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_power();
    t_direct();
    t_defer();
    t_bcast();
    t_limit();
    t_current();
    t_alarm();
    t_supply();
    finish_test();
  end
endmodule // bias_dac_channel_control_tb
`default_nettype wire
